// >>> core/clk_rst_seq.sv
// Clock prescaler, reset sequencer and its control registers
`timescale 1ns/1ps

module clk_rst_seq #(
  parameter int POR_CYCLES_P  = clk_rst_seq_pkg::POR_CYCLES,
  parameter int WDOG_CYCLES_P = clk_rst_seq_pkg::WDOG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // Register port
  input  wire clk_rst_seq_pkg::reg_req_s req_i,
  output logic [7:0]                     rdata_o,
  // Supply and power events
  input  wire logic                      brownout_i,
  input  wire logic                      low_volt_i,
  input  wire logic                      high_volt_i,
  input  wire logic                      halt_req_i,
  input  wire logic                      stop_req_i,
  input  wire logic                      wake_event_i,
  input  wire logic                      irq_request_i,
  input  wire logic                      watchdog_service_i,
  input  wire logic                      watchdog_enable_i,
  input  wire logic                      watchdog_timer_clear_i,
  input  wire logic                      short_reset_timer_clear_i,
  // Clocks and reset out
  output clk_rst_seq_pkg::clk_out_s      clk_o,
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    clk_rst_seq_pkg::seq_state_e st;
    logic [31:0]                 tmr;
    logic [31:0]                 wdog;
    logic                        div2;
    logic [3:0]                  pre;
    logic                        div16_act;
    logic [7:0]                  main;
    logic [7:0]                  route;
    logic [7:0]                  p2chg;
    logic [7:0]                  comb;
    logic [7:0]                  p3chg;
    logic [7:0]                  wmode;
    logic                        vd_en;
    logic [2:0]                  irq_st;
    logic [2:0]                  irq_mask;
    logic                        watchdog_timer_clear_q;
    logic                        short_reset_timer_clear_q;
    logic [7:0]                  rdata;
    clk_rst_seq_pkg::clk_out_s   clk;
    logic                        irq;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  function automatic logic [7:0] reg_read(input state_s s, input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      clk_rst_seq_pkg::OFS_VOLT_DETECT:
        v = {clk_rst_seq_pkg::VOLT_RESET_HI[7:3], high_volt_i & s.vd_en,
             low_volt_i & s.vd_en, s.vd_en};
      clk_rst_seq_pkg::OFS_ROUTE_STATUS:  v = s.route;
      clk_rst_seq_pkg::OFS_MAIN_CTRL:     v = s.main;
      clk_rst_seq_pkg::OFS_PORT2_CHANGE:  v = s.p2chg;
      clk_rst_seq_pkg::OFS_COMBINATION:   v = s.comb;
      clk_rst_seq_pkg::OFS_PORT3_CHANGE:  v = s.p3chg;
      clk_rst_seq_pkg::OFS_WATCHDOG_MODE: v = s.wmode;
      clk_rst_seq_pkg::OFS_IRQ_STATUS:    v = {5'h00, s.irq_st};
      clk_rst_seq_pkg::OFS_IRQ_MASK:      v = {5'h00, s.irq_mask};
      default:                            v = 8'h00;
    endcase
    return v;
  endfunction

  // Full defaults for power-on, brownout and watchdog resets
  function automatic state_s por_defaults(input state_s s);
    state_s r;
    r = s;
    r.main     = clk_rst_seq_pkg::MAIN_RESET;
    r.route    = clk_rst_seq_pkg::ROUTE_RESET;
    r.p2chg    = 8'h00;
    r.comb     = 8'h00;
    r.p3chg    = 8'h00;
    r.wmode    = clk_rst_seq_pkg::WATCHDOG_MODE_RESET;
    r.vd_en    = 1'b0;
    r.irq_mask = 3'h0;
    r.irq_st   = 3'h0;
    r.div16_act = 1'b0;
    r.wdog     = 32'h0;
    return r;
  endfunction

  logic       wd_timeout;
  logic [2:0] irq_set;
  logic       div_tick;

  always_comb begin
    nxt_st = st_ff;
    wd_timeout = watchdog_enable_i && (st_ff.st == clk_rst_seq_pkg::ST_RUN)
                 && (st_ff.wdog >= 32'(WDOG_CYCLES_P - 1));
    irq_set = 3'h0;
    irq_set[clk_rst_seq_pkg::IRQ_LOW_VOLT_BIT] = st_ff.vd_en & low_volt_i;
    irq_set[clk_rst_seq_pkg::IRQ_WDOG_BIT]     = wd_timeout;

    // Divide by two, then an optional sixteen from the same counter
    nxt_st.div2 = ~st_ff.div2;
    if (st_ff.div2) begin
      nxt_st.pre = st_ff.pre + 4'h1;
    end
    div_tick = st_ff.div2 && (!st_ff.div16_act || st_ff.pre == 4'hf);
    // Switching only at the wrap keeps every divided pulse full length
    if (st_ff.div2 && st_ff.pre == 4'hf) begin
      nxt_st.div16_act = st_ff.main[clk_rst_seq_pkg::MAIN_DIV16_BIT];
    end

    // Register writes
    if (req_i.wr && st_ff.st != clk_rst_seq_pkg::ST_POR_WAIT) begin
      case (req_i.addr)
        clk_rst_seq_pkg::OFS_VOLT_DETECT:
          nxt_st.vd_en = req_i.wdata[clk_rst_seq_pkg::VD_ENABLE_BIT];
        clk_rst_seq_pkg::OFS_ROUTE_STATUS:  nxt_st.route = req_i.wdata;
        clk_rst_seq_pkg::OFS_MAIN_CTRL: begin
          // Stop flag is hardware owned and read only
          nxt_st.main = (req_i.wdata & clk_rst_seq_pkg::MAIN_SW_MASK)
                        | (st_ff.main & ~clk_rst_seq_pkg::MAIN_SW_MASK);
        end
        clk_rst_seq_pkg::OFS_PORT2_CHANGE:  nxt_st.p2chg = req_i.wdata;
        clk_rst_seq_pkg::OFS_COMBINATION:   nxt_st.comb = req_i.wdata;
        clk_rst_seq_pkg::OFS_PORT3_CHANGE:  nxt_st.p3chg = req_i.wdata;
        clk_rst_seq_pkg::OFS_WATCHDOG_MODE: nxt_st.wmode = req_i.wdata;
        clk_rst_seq_pkg::OFS_IRQ_STATUS:
          nxt_st.irq_st = st_ff.irq_st & ~req_i.wdata[2:0];
        clk_rst_seq_pkg::OFS_IRQ_MASK:      nxt_st.irq_mask = req_i.wdata[2:0];
        default: ;
      endcase
    end

    // Watchdog interval counter, cleared by the service instruction
    // Held at zero while disabled, so enabling it never fires at once
    if (watchdog_service_i || !watchdog_enable_i
        || st_ff.st != clk_rst_seq_pkg::ST_RUN) begin
      nxt_st.wdog = 32'h0;
    end else if (div_tick) begin
      nxt_st.wdog = st_ff.wdog + 32'h1;
    end

    nxt_st.watchdog_timer_clear_q = watchdog_timer_clear_i;
    nxt_st.short_reset_timer_clear_q = short_reset_timer_clear_i;
    if (st_ff.tmr != 32'h0) begin
      nxt_st.tmr = st_ff.tmr - 32'h1;
    end

    case (st_ff.st)
      clk_rst_seq_pkg::ST_POR_WAIT: begin
        if (st_ff.tmr == 32'h0) begin
          nxt_st.st = clk_rst_seq_pkg::ST_RUN;
        end
      end
      clk_rst_seq_pkg::ST_SHORT_WAIT: begin
        if (st_ff.tmr == 32'h0) begin
          nxt_st.st = clk_rst_seq_pkg::ST_RUN;
        end
      end
      clk_rst_seq_pkg::ST_RUN: begin
        if (stop_req_i) begin
          nxt_st.st = clk_rst_seq_pkg::ST_STOP;
        end else if (halt_req_i) begin
          nxt_st.st = clk_rst_seq_pkg::ST_HALT;
        end
      end
      clk_rst_seq_pkg::ST_HALT: begin
        if (irq_request_i) begin
          nxt_st.st = clk_rst_seq_pkg::ST_RUN;
        end
      end
      clk_rst_seq_pkg::ST_STOP: begin
        if (wake_event_i) begin
          // Recovery: prescaler select and interrupt mask cleared, wake status and stop flag set
          nxt_st.main[clk_rst_seq_pkg::MAIN_STOP_FLAG_BIT] = 1'b1;
          nxt_st.main[clk_rst_seq_pkg::MAIN_DIV16_BIT] = 1'b0;
          nxt_st.div16_act = 1'b0;
          nxt_st.irq_mask = 3'h0;
          nxt_st.irq_st[clk_rst_seq_pkg::IRQ_WAKE_BIT] = 1'b1;
          if (st_ff.main[clk_rst_seq_pkg::MAIN_DELAY_BIT]) begin
            nxt_st.st = clk_rst_seq_pkg::ST_POR_WAIT;
            nxt_st.tmr = 32'(POR_CYCLES_P - 1);
          end else begin
            nxt_st.st = clk_rst_seq_pkg::ST_RUN;
          end
        end
      end
      clk_rst_seq_pkg::ST_BROWNOUT: begin
        if (!brownout_i) begin
          nxt_st.st = clk_rst_seq_pkg::ST_POR_WAIT;
          nxt_st.tmr = 32'(POR_CYCLES_P - 1);
        end
      end
      default: nxt_st.st = clk_rst_seq_pkg::ST_POR_WAIT;
    endcase

    // Rising clear inputs start the long or the short timer
    if (watchdog_timer_clear_i && !st_ff.watchdog_timer_clear_q) begin
      nxt_st = por_defaults(nxt_st);
      nxt_st.st = clk_rst_seq_pkg::ST_POR_WAIT;
      nxt_st.tmr = 32'(POR_CYCLES_P - 1);
    end else if (short_reset_timer_clear_i && !st_ff.short_reset_timer_clear_q) begin
      nxt_st.st = clk_rst_seq_pkg::ST_SHORT_WAIT;
      nxt_st.tmr = 32'(clk_rst_seq_pkg::SHORT_RESET_CLOCKS - 1);
    end

    if (wd_timeout) begin
      nxt_st = por_defaults(nxt_st);
      nxt_st.st = clk_rst_seq_pkg::ST_POR_WAIT;
      nxt_st.tmr = 32'(POR_CYCLES_P - 1);
    end

    if (brownout_i) begin
      nxt_st = por_defaults(nxt_st);
      nxt_st.st = clk_rst_seq_pkg::ST_BROWNOUT;
      nxt_st.tmr = 32'h0;
    end

    // Sticky status: hardware set wins over a same-cycle clear
    nxt_st.irq_st = nxt_st.irq_st | irq_set;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);

    nxt_st.rdata = req_i.rd ? reg_read(st_ff, req_i.addr) : 8'h00;

    nxt_st.clk.osc_run = (nxt_st.st != clk_rst_seq_pkg::ST_STOP)
                         && (nxt_st.st != clk_rst_seq_pkg::ST_BROWNOUT);
    nxt_st.clk.sys_reset = (nxt_st.st == clk_rst_seq_pkg::ST_POR_WAIT)
                           || (nxt_st.st == clk_rst_seq_pkg::ST_SHORT_WAIT)
                           || (nxt_st.st == clk_rst_seq_pkg::ST_BROWNOUT);
    nxt_st.clk.core_en = div_tick && (st_ff.st == clk_rst_seq_pkg::ST_RUN);
    nxt_st.clk.halt_clk_en = div_tick && (st_ff.st == clk_rst_seq_pkg::ST_RUN
                             || st_ff.st == clk_rst_seq_pkg::ST_HALT);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.st <= clk_rst_seq_pkg::ST_POR_WAIT;
      st_ff.tmr <= 32'(POR_CYCLES_P - 1);
      st_ff.main <= clk_rst_seq_pkg::MAIN_RESET;
      st_ff.wmode <= clk_rst_seq_pkg::WATCHDOG_MODE_RESET;
      st_ff.clk.sys_reset <= 1'b1;
      st_ff.clk.osc_run <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign clk_o   = st_ff.clk;
  assign irq_o   = st_ff.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_halt_gates_core: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(st_ff.st) == clk_rst_seq_pkg::ST_HALT |-> !clk_o.core_en)
    else $error("core clock ran in halt");
  chk_stop_osc_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.st == clk_rst_seq_pkg::ST_STOP |-> !clk_o.osc_run)
    else $error("oscillator ran in stop");
  chk_brownout_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
    brownout_i |=> clk_o.sys_reset && !clk_o.osc_run)
    else $error("brownout did not hold reset");
  chk_fast_wake: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.st == clk_rst_seq_pkg::ST_STOP && wake_event_i && !brownout_i
    && !st_ff.main[clk_rst_seq_pkg::MAIN_DELAY_BIT] && !wd_timeout
    && !(watchdog_timer_clear_i && !st_ff.watchdog_timer_clear_q)
    && !(short_reset_timer_clear_i && !st_ff.short_reset_timer_clear_q)
    |=> st_ff.st == clk_rst_seq_pkg::ST_RUN && !clk_o.sys_reset)
    else $error("fast recovery did not run at once");
  chk_wake_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.st == clk_rst_seq_pkg::ST_STOP && wake_event_i && !brownout_i && !wd_timeout
    && !(watchdog_timer_clear_i && !st_ff.watchdog_timer_clear_q)
    |=> st_ff.main[clk_rst_seq_pkg::MAIN_STOP_FLAG_BIT]
    && !st_ff.main[clk_rst_seq_pkg::MAIN_DIV16_BIT])
    else $error("recovery flag or prescaler wrong");
  chk_wake_delay: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.st == clk_rst_seq_pkg::ST_STOP && wake_event_i
    && st_ff.main[clk_rst_seq_pkg::MAIN_DELAY_BIT] |=> clk_o.sys_reset [*8])
    else $error("delayed recovery skipped the timer");
  chk_wdog_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
    wd_timeout |=> clk_o.sys_reset && st_ff.main == clk_rst_seq_pkg::MAIN_RESET)
    else $error("watchdog did not reset");
  chk_short_timer: assert property (@(posedge mclk_i) disable iff (rst_i)
    short_reset_timer_clear_i && !st_ff.short_reset_timer_clear_q && !watchdog_timer_clear_i && !brownout_i
    && !wd_timeout |=> clk_o.sys_reset [*8])
    else $error("short reset too brief");
  chk_div_tick: assert property (@(posedge mclk_i) disable iff (rst_i)
    clk_o.halt_clk_en |=> !clk_o.halt_clk_en)
    else $error("halt clock not divided");
  chk_lv_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.vd_en && low_volt_i && !brownout_i
    |=> st_ff.irq_st[clk_rst_seq_pkg::IRQ_LOW_VOLT_BIT])
    else $error("low voltage flag lost");
endmodule

// >>> core/clk_rst_seq_pkg.sv
// Constants and carrier types for the clock prescaler and reset sequencer
package clk_rst_seq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_VOLT_DETECT   = 12'hd0c;
  localparam logic [11:0] OFS_ROUTE_STATUS  = 12'hf0a;
  localparam logic [11:0] OFS_MAIN_CTRL     = 12'hf0b;
  localparam logic [11:0] OFS_PORT2_CHANGE  = 12'hf0c;
  localparam logic [11:0] OFS_COMBINATION   = 12'hf0d;
  localparam logic [11:0] OFS_PORT3_CHANGE  = 12'hf0e;
  localparam logic [11:0] OFS_WATCHDOG_MODE = 12'hf0f;
  localparam logic [11:0] OFS_IRQ_STATUS    = 12'hf10;
  localparam logic [11:0] OFS_IRQ_MASK      = 12'hf11;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MAIN_STOP_FLAG_BIT   = 7;
  localparam int          MAIN_DELAY_BIT       = 5;
  localparam int          MAIN_DIV16_BIT       = 0;
  localparam logic [7:0]  MAIN_SW_MASK         = 8'h7d;
  localparam logic [7:0]  MAIN_RESET           = 8'h20;
  localparam logic [7:0]  VOLT_RESET_HI        = 8'hf8;
  localparam logic [7:0]  ROUTE_RESET          = 8'h00;
  localparam logic [7:0]  WATCHDOG_MODE_RESET  = 8'h0d;
  localparam int          VD_ENABLE_BIT        = 0;
  localparam int          VD_LOW_BIT           = 1;
  localparam int          VD_HIGH_BIT          = 2;

  // Interrupt status bits
  localparam int          IRQ_LOW_VOLT_BIT     = 0;
  localparam int          IRQ_WAKE_BIT         = 1;
  localparam int          IRQ_WDOG_BIT         = 2;
  localparam int          IRQ_W                = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ              = 20;
  localparam int          POR_TIME_US          = 5000;
  localparam int          POR_CYCLES           = POR_TIME_US * CLK_MHZ;
  localparam int          SHORT_RESET_CLOCKS   = 18;
  localparam int          PRESCALE_DIV         = 16;
  localparam int          WDOG_CYCLES_DEF      = 65536;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_BROWNOUT,
    ST_SHORT_WAIT
  } seq_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic core_en;
    logic halt_clk_en;
    logic osc_run;
    logic sys_reset;
  } clk_out_s;

endpackage

// >>> testbench/supply_model.sv
// Behavioural model of the supply comparator and stop-recovery wake source
`timescale 1ns/1ps
module supply_model #(
  parameter int WAKE_HOLD = 12
) (
  // Clock
  input  wire logic mclk_i,
  // Commands from the bench
  input  wire logic sag_i,
  input  wire logic low_i,
  input  wire logic wake_cmd_i,
  // Signals into the sequencer
  output logic      brownout_o,
  output logic      low_volt_o,
  output logic      high_volt_o,
  output logic      wake_o
);
  int hold_cnt = 0;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // No hysteresis: the bench decides every crossing itself
  always_comb begin
    brownout_o  = sag_i;
    low_volt_o  = low_i & ~sag_i;
    high_volt_o = ~low_i & ~sag_i;
  end

  // ----------------------------------------------------------------
  // Wake source
  // ----------------------------------------------------------------
  // Held past the minimum so a bypassed delay still sees the wake
  always @(posedge mclk_i) begin
    if (wake_cmd_i) begin
      hold_cnt <= WAKE_HOLD;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  assign wake_o = (hold_cnt > 0);
endmodule

// >>> testbench/tb_top.sv
// Self-checking testbench for the clock prescaler and reset sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int POR  = 20;
  localparam int WDOG = 16;
  localparam int P_HALT = 0, P_STOP = 1, P_SERVICE = 2, P_WAKE = 3;
  logic                      mclk_i, rst_i;
  clk_rst_seq_pkg::reg_req_s req_i;
  logic [7:0]                rdata_o;
  logic                      brownout_i, low_volt_i, high_volt_i, halt_req_i, stop_req_i;
  logic                      wake_event_i, irq_request_i, watchdog_service_i, watchdog_enable_i;
  logic                      watchdog_timer_clear_i, short_reset_timer_clear_i;
  clk_rst_seq_pkg::clk_out_s clk_o;
  logic                      irq_o, sag, low, wake_cmd;
  int                        miscompares = 0;
  int                        total_checks = 0;

  clk_rst_seq #(.POR_CYCLES_P(POR), .WDOG_CYCLES_P(WDOG)) clk_rst_seq_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .brownout_i(brownout_i), .low_volt_i(low_volt_i), .high_volt_i(high_volt_i),
    .halt_req_i(halt_req_i), .stop_req_i(stop_req_i), .wake_event_i(wake_event_i),
    .irq_request_i(irq_request_i), .watchdog_service_i(watchdog_service_i),
    .watchdog_enable_i(watchdog_enable_i), .watchdog_timer_clear_i(watchdog_timer_clear_i),
    .short_reset_timer_clear_i(short_reset_timer_clear_i), .clk_o(clk_o), .irq_o(irq_o));

  supply_model supply_model_inst (
    .mclk_i(mclk_i), .sag_i(sag), .low_i(low), .wake_cmd_i(wake_cmd),
    .brownout_o(brownout_i), .low_volt_o(low_volt_i), .high_volt_o(high_volt_i),
    .wake_o(wake_event_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req_i.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    req_i.rd <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic expect_reg(input string what, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    check(what, {8'h00, d}, {8'h00, e});
  endtask

  task automatic drive_pulse(input int sel, input logic v);
    case (sel)
      P_HALT:    halt_req_i         <= v;
      P_STOP:    stop_req_i         <= v;
      P_SERVICE: watchdog_service_i <= v;
      default:   wake_cmd           <= v;
    endcase
  endtask

  task automatic pulse(input int sel);
    @(posedge mclk_i);
    drive_pulse(sel, 1'b1);
    @(posedge mclk_i);
    drive_pulse(sel, 1'b0);
  endtask

  // Waits up to wmax cycles for reset, then counts how long it stays high
  task automatic reset_len(input int wmax, output int w, output int n);
    w = 0;
    n = 0;
    @(posedge mclk_i);
    #1;
    while (clk_o.sys_reset !== 1'b1 && w < wmax) begin
      w++;
      @(posedge mclk_i);
      #1;
    end
    while (clk_o.sys_reset === 1'b1 && n < 2000) begin
      n++;
      @(posedge mclk_i);
      #1;
    end
  endtask

  task automatic count_en(input int cyc, output int c, output int h);
    c = 0;
    h = 0;
    repeat (cyc) begin
      @(posedge mclk_i);
      #1;
      c += (clk_o.core_en === 1'b1);
      h += (clk_o.halt_clk_en === 1'b1);
    end
  endtask

  task automatic core_gap(output int g);
    int k;
    g = 0;
    k = 0;
    @(posedge mclk_i);
    #1;
    while (clk_o.core_en !== 1'b1 && k < 100) begin
      k++;
      @(posedge mclk_i);
      #1;
    end
    do begin
      g++;
      @(posedge mclk_i);
      #1;
    end while (clk_o.core_en !== 1'b1 && g < 100);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    expect_reg("main ctrl", 12'hf0b, 8'h20);
    expect_reg("volt ctrl", 12'hd0c, 8'hf8);
    expect_reg("route", 12'hf0a, 8'h00);
    expect_reg("wdog mode", 12'hf0f, 8'h0d);
    expect_reg("unmapped", 12'h123, 8'h00);
    reg_wr(12'hd0c, 8'hff);
    expect_reg("volt enabled", 12'hd0c, 8'hfd);
    reg_wr(12'hd0c, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_prescale();
    int g;
    core_gap(g);
    check("gap div2", 16'(g), 16'h0002);
    reg_wr(12'hf0b, 8'h21);
    repeat (70) @(posedge mclk_i);
    core_gap(g);
    check("gap div32", 16'(g), 16'h0020);
    reg_wr(12'hf0b, 8'h20);
    repeat (70) @(posedge mclk_i);
    core_gap(g);
    check("gap back", 16'(g), 16'h0002);
    $display("test prescale done");
  endtask

  task automatic test_halt();
    int c, h;
    pulse(P_HALT);
    repeat (3) @(posedge mclk_i);
    count_en(40, c, h);
    check("core in halt", 16'(c), 16'h0000);
    check("halt clk runs", {15'h0, h > 0}, 16'h0001);
    check("osc in halt", {15'h0, clk_o.osc_run}, 16'h0001);
    @(posedge mclk_i);
    irq_request_i <= 1'b1;
    count_en(10, c, h);
    check("core resumes", {15'h0, c > 0}, 16'h0001);
    irq_request_i <= 1'b0;
    $display("test halt done");
  endtask

  // Delay bit set models a crystal source, clear an external clock
  task automatic test_stop(input logic delay);
    int c, h, w, n;
    reg_wr(12'hf0b, {2'b00, delay, 5'b00001});
    repeat (70) @(posedge mclk_i);
    pulse(P_STOP);
    repeat (3) @(posedge mclk_i);
    count_en(10, c, h);
    check("core in stop", 16'(c), 16'h0000);
    check("osc in stop", {15'h0, clk_o.osc_run}, 16'h0000);
    pulse(P_WAKE);
    reset_len(10, w, n);
    if (delay) begin
      check("wake por", {15'h0, n >= POR && n <= POR + 2}, 16'h0001);
    end else begin
      check("wake bypass", 16'(n), 16'h0000);
    end
    check("osc back", {15'h0, clk_o.osc_run}, 16'h0001);
    expect_reg("stop flag", 12'hf0b, {2'b10, delay, 5'b00000});
    reg_wr(12'hf0b, 8'h20);
    $display("test stop done");
  endtask

  task automatic test_brownout();
    int w, n;
    @(posedge mclk_i);
    sag <= 1'b1;
    repeat (5) @(posedge mclk_i);
    #1;
    check("bo reset", {15'h0, clk_o.sys_reset}, 16'h0001);
    check("bo osc", {15'h0, clk_o.osc_run}, 16'h0000);
    sag <= 1'b0;
    reset_len(10, w, n);
    check("bo por", {15'h0, n >= POR && n <= POR + 2}, 16'h0001);
    expect_reg("bo main", 12'hf0b, 8'h20);
    $display("test brownout done");
  endtask

  task automatic test_watchdog();
    int w, n;
    @(posedge mclk_i);
    watchdog_enable_i <= 1'b1;
    pulse(P_SERVICE);
    reset_len(200, w, n);
    check("wdog time", {15'h0, w >= 2 * WDOG - 4 && w <= 2 * WDOG + 8}, 16'h0001);
    check("wdog por", {15'h0, n >= POR && n <= POR + 2}, 16'h0001);
    watchdog_enable_i <= 1'b0;
    expect_reg("wdog main", 12'hf0b, 8'h20);
    $display("test watchdog done");
  endtask

  task automatic test_low_volt();
    // Earlier tests leave the watchdog bit pending
    reg_wr(12'hf10, 8'h07);
    reg_wr(12'hd0c, 8'h01);
    reg_wr(12'hf11, 8'h01);
    low <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 check("lv irq", {15'h0, irq_o}, 16'h0001);
    expect_reg("lv status", 12'hf10, 8'h01);
    low <= 1'b0;
    reg_wr(12'hf10, 8'h01);
    reg_wr(12'hf11, 8'h00);
    low <= 1'b1;
    repeat (4) @(posedge mclk_i);
    low <= 1'b0;
    #1 check("lv masked", {15'h0, irq_o}, 16'h0000);
    reg_wr(12'hf11, 8'h01);
    repeat (2) @(posedge mclk_i);
    #1 check("lv pending", {15'h0, irq_o}, 16'h0001);
    reg_wr(12'hf10, 8'h07);
    repeat (2) @(posedge mclk_i);
    #1 check("lv cleared", {15'h0, irq_o}, 16'h0000);
    $display("test low voltage done");
  endtask

  task automatic test_clears();
    int w, n;
    @(posedge mclk_i);
    short_reset_timer_clear_i <= 1'b1;
    reset_len(10, w, n);
    check("short reset", {15'h0, n >= 18 && n <= 20}, 16'h0001);
    short_reset_timer_clear_i <= 1'b0;
    watchdog_timer_clear_i <= 1'b1;
    reset_len(10, w, n);
    check("long reset", {15'h0, n >= POR && n <= POR + 2}, 16'h0001);
    watchdog_timer_clear_i <= 1'b0;
    $display("test clears done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    int w, n;
    rst_i = 1'b1;
    req_i = '0;
    {halt_req_i, stop_req_i, irq_request_i, watchdog_service_i, watchdog_enable_i} = '0;
    {watchdog_timer_clear_i, short_reset_timer_clear_i, sag, low, wake_cmd} = '0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 check("reset held", {15'h0, clk_o.sys_reset}, 16'h0001);
    reset_len(10, w, n);
    // The release cycle itself was seen above, so n counts one less
    check("por length", {15'h0, n >= POR - 1 && n <= POR + 1}, 16'h0001);
    test_regs();
    test_prescale();
    test_halt();
    test_stop(1'b1);
    test_stop(1'b0);
    test_brownout();
    test_watchdog();
    test_low_volt();
    test_clears();
    results();
  end

  // Whole run needs well under a thousand cycles; this is far beyond that
  initial begin
    #500us;
    miscompares++;
    results();
  end
endmodule
